/* File: src/lsc_light_sensor.sv */
/*
  Command register, result registers, two-wire serial slave and the
  integration engine of a light-to-digital sensor.
  Assumes sys_clk at 125 MHz, scl/sda/pins asynchronous to it and sampled
  here; photodiode charge-balance pulses arrive as asynchronous levels whose
  high and low phases each last at least three sys_clk cycles.
*/
// What this block does
// - command register is host read/write and holds until rewritten.
// - command bit 7 powers up at one, powers down at zero.
// - bit 6 at zero: one measurement, then automatic shutdown.
// - bit 6 at one: conversions repeat back to back.
// - bit 5 picks ambient (0) or infrared (1) photodiode.
// - bits 4:2 codes 000..011 give internal timing, 16/12/8/4 bit results.
// - code 100 external timing with ADC result; 101 shows timer count.
// - bits 3:2 give 65536, 4096, 256 or 16 oscillator cycles.
// - external integration spans two consecutive sync writes.
// - external timer mode counts oscillator cycles between syncs, shown in 01h/02h.
// - bits 1:0 select one of four full-scale spans.
// - result bytes are read-only; writes leave them untouched.
// - high byte at 02, low byte at 01.
// - both result bytes reload at the end of every conversion, except when a command write lands in that same cycle.
// - write with register address bit 7 set restarts external integration.
// - after reset powered down, result bytes zero.
// - after one-time conversion power down, result stays readable.
// - slave address 1000100 or 1000101 from the address select pin.
module lsc_light_sensor
  import lsc_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       address_select_pin,
  input  wire logic       ambient_pulse,
  input  wire logic       infrared_pulse,
  output logic            analog_enable,
  output logic            infrared_select,
  output logic [1:0]      full_scale_span,
  output logic            conversion_done
);
  // the tick divider is 16 bits wide and needs at least two cycles per tick
  if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_div_check
    $error("OSC_DIV out of range");
  end

  // input synchronisers: stage 1 feeds stage 2 only, stage 3 is the edge history
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [3:0] prev_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: bus lines high, pulse inputs low, so no false edge follows reset
      sync1_ff <= 5'h03;
      sync2_ff <= 5'h03;
      prev_ff  <= 4'h3;
    end else begin
      sync1_ff <= {address_select_pin, infrared_pulse, ambient_pulse, sda_in, scl_in};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[3:0];
    end
  end

  wire scl_s     = sync2_ff[0];
  wire sda_s     = sync2_ff[1];
  wire scl_rise  = scl_s && !prev_ff[0];
  wire scl_fall  = !scl_s && prev_ff[0];
  wire bus_start = scl_s && prev_ff[0] && !sda_s && prev_ff[1];
  wire bus_stop  = scl_s && prev_ff[0] && sda_s && !prev_ff[1];
  // charge-balance pulse edges and the address strap
  wire amb_rise  = sync2_ff[2] && !prev_ff[2];
  wire ir_rise   = sync2_ff[3] && !prev_ff[3];
  wire addr_pin_s = sync2_ff[4];

  // registers
  logic [7:0]  cmd_ff;
  logic [15:0] result_ff;
  logic [15:0] held_adc_ff;
  logic [15:0] held_timer_ff;

  // command fields used by the engine
  wire ext_mode   = cmd_ff[TIMING_SOURCE_BIT];
  wire timer_view = cmd_ff[CYCLE_COUNT_LOW];
  wire continuous = cmd_ff[CMD_MODE_BIT];

  // serial slave
  lsc_bus_t   bus_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [6:0] ptr_ff;
  logic       rw_ff;
  logic       nack_ff;
  logic       cmd_wr_ff;
  logic [7:0] cmd_wdata_ff;
  logic       sync_ff;

  // address match and read data select; unmapped offsets read as zero
  wire [6:0] my_addr   = {SLAVE_ADDR_HIGH, addr_pin_s};
  wire       addr_hit  = (shift_ff[7:1] == my_addr);
  wire [7:0] rd_byte   = (ptr_ff == REG_COMMAND_CONTROL)  ? cmd_ff :
                         (ptr_ff == REG_RESULT_LOW_BYTE)  ? result_ff[7:0] :
                         (ptr_ff == REG_RESULT_HIGH_BYTE) ? result_ff[15:8] : 8'h00;
  wire [3:0] tx_index  = 4'h7 - bit_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ff       <= LSC_BUS_IDLE;
      bit_ff       <= 4'h0;
      shift_ff     <= 8'h00;
      tx_ff        <= 8'h00;
      ptr_ff       <= 7'h00;
      rw_ff        <= 1'b0;
      nack_ff      <= 1'b0;
      sda_oe       <= 1'b0;
      sda_out      <= 1'b0;
      cmd_wr_ff    <= 1'b0;
      cmd_wdata_ff <= 8'h00;
      sync_ff      <= 1'b0;
    end else begin
      cmd_wr_ff <= 1'b0;
      sync_ff   <= 1'b0;
      // start and stop override any bit in progress
      if (bus_start) begin
        bus_ff <= LSC_BUS_ADDR;
        bit_ff <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        bus_ff <= LSC_BUS_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_ff != LSC_BUS_IDLE && scl_rise) begin
        if (bit_ff < BIT_ACK) begin
          shift_ff <= {shift_ff[6:0], sda_s};
          bit_ff   <= bit_ff + 4'h1;
        end else if (bit_ff == BIT_ACK) begin
          nack_ff <= sda_s;
          bit_ff  <= BIT_POST;
        end
      end else if (bus_ff != LSC_BUS_IDLE && scl_fall) begin
        // sda only moves while scl is low, a few cycles after its fall
        if (bus_ff == LSC_BUS_RD && bit_ff < BIT_ACK) begin
          sda_oe <= !tx_ff[tx_index[2:0]];
        end else if (bit_ff == BIT_ACK) begin
          sda_oe <= (bus_ff != LSC_BUS_RD) && (bus_ff != LSC_BUS_ADDR || addr_hit);
          unique case (bus_ff)
            LSC_BUS_ADDR: begin
              rw_ff <= shift_ff[0];
              if (!addr_hit) begin
                bus_ff <= LSC_BUS_IDLE;
              end
            end
            LSC_BUS_REG: begin
              ptr_ff  <= shift_ff[6:0];
              sync_ff <= shift_ff[SYNC_ADDR_BIT];
            end
            LSC_BUS_WR: begin
              // only the command offset takes data; result bytes ignore writes
              cmd_wr_ff    <= (ptr_ff == REG_COMMAND_CONTROL);
              cmd_wdata_ff <= shift_ff;
              ptr_ff       <= ptr_ff + 7'h01;
            end
            default: begin
            end
          endcase
        end else if (bit_ff == BIT_POST) begin
          // ack slot over: load the next read byte or move to the next phase
          bit_ff <= 4'h0;
          sda_oe <= 1'b0;
          if ((bus_ff == LSC_BUS_ADDR && rw_ff) || (bus_ff == LSC_BUS_RD && !nack_ff)) begin
            bus_ff <= LSC_BUS_RD;
            tx_ff  <= rd_byte;
            ptr_ff <= ptr_ff + 7'h01;
            sda_oe <= !rd_byte[7];
          end else if (bus_ff == LSC_BUS_RD) begin
            bus_ff <= LSC_BUS_IDLE;
          end else if (bus_ff == LSC_BUS_ADDR) begin
            bus_ff <= LSC_BUS_REG;
          end else begin
            bus_ff <= LSC_BUS_WR;
          end
        end
      end
    end
  end

  // internal oscillator tick
  logic [15:0] div_ff;
  wire osc_tick = (div_ff == 16'(OSC_DIV - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= osc_tick ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  // integration engine
  lsc_eng_t    eng_ff;
  logic [16:0] tick_cnt_ff;
  logic [16:0] adc_cnt_ff;

  wire [16:0] target = (cmd_ff[3:2] == 2'b00) ? CYCLES_RES16 :
                       (cmd_ff[3:2] == 2'b01) ? CYCLES_RES12 :
                       (cmd_ff[3:2] == 2'b10) ? CYCLES_RES8  : CYCLES_RES4;
  wire [16:0] res_max    = target - 17'h00001;
  wire        light_edge = cmd_ff[CMD_LIGHT_BIT] ? ir_rise : amb_rise;
  wire        int_done   = (eng_ff == LSC_ENG_RUN) && !ext_mode && osc_tick &&
                           (tick_cnt_ff == res_max);
  wire        ext_done   = (eng_ff == LSC_ENG_RUN) && ext_mode && sync_ff;
  wire [16:0] int_res    = (adc_cnt_ff > res_max) ? res_max : adc_cnt_ff;
  wire [16:0] ext_adc    = (adc_cnt_ff > COUNT_MAX) ? COUNT_MAX : adc_cnt_ff;
  wire [16:0] ext_tmr    = (tick_cnt_ff > COUNT_MAX) ? COUNT_MAX : tick_cnt_ff;
  // fields of the byte being written, seen as the command takes it
  wire        wr_enable  = cmd_wdata_ff[CMD_ENABLE_BIT];
  wire        wr_ext     = cmd_wdata_ff[TIMING_SOURCE_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= COMMAND_RESET;
    end else if (cmd_wr_ff) begin
      cmd_ff <= cmd_wdata_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_ff          <= LSC_ENG_OFF;
      tick_cnt_ff     <= 17'h00000;
      adc_cnt_ff      <= 17'h00000;
      result_ff       <= RESULT_RESET;
      held_adc_ff     <= RESULT_RESET;
      held_timer_ff   <= RESULT_RESET;
      conversion_done <= 1'b0;
    end else begin
      conversion_done <= int_done || ext_done;
      // counters run only while integrating and saturate one past 16 bits
      if (eng_ff == LSC_ENG_RUN) begin
        if (osc_tick && tick_cnt_ff <= COUNT_MAX) begin
          tick_cnt_ff <= tick_cnt_ff + 17'h00001;
        end
        if (light_edge && adc_cnt_ff <= COUNT_MAX) begin
          adc_cnt_ff <= adc_cnt_ff + 17'h00001;
        end
      end
      if (cmd_wr_ff) begin
        if (!wr_enable) begin
          eng_ff <= LSC_ENG_OFF;
        end else if (!wr_ext) begin
          eng_ff      <= LSC_ENG_RUN;
          tick_cnt_ff <= 17'h00000;
          adc_cnt_ff  <= 17'h00000;
        end else begin
          // external timing: a running external integration goes on, only the shown value swaps
          if (eng_ff == LSC_ENG_OFF || !ext_mode) begin
            eng_ff <= LSC_ENG_WAIT;
          end
          result_ff <= cmd_wdata_ff[CYCLE_COUNT_LOW] ? held_timer_ff : held_adc_ff;
        end
      end else if (int_done) begin
        // one-time mode stops here but keeps the command as written
        result_ff   <= int_res[15:0];
        tick_cnt_ff <= 17'h00000;
        adc_cnt_ff  <= 17'h00000;
        if (!continuous) begin
          eng_ff <= LSC_ENG_OFF;
        end
      end else if (ext_done) begin
        held_adc_ff   <= ext_adc[15:0];
        held_timer_ff <= ext_tmr[15:0];
        result_ff     <= timer_view ? ext_tmr[15:0] : ext_adc[15:0];
        tick_cnt_ff   <= 17'h00000;
        adc_cnt_ff    <= 17'h00000;
        if (!continuous) begin
          eng_ff <= LSC_ENG_OFF;
        end
      end else if (eng_ff == LSC_ENG_WAIT && sync_ff && ext_mode) begin
        // first sync after an external-timing command opens the integration
        eng_ff      <= LSC_ENG_RUN;
        tick_cnt_ff <= 17'h00000;
        adc_cnt_ff  <= 17'h00000;
      end
    end
  end

  // analog controls follow the engine and command one cycle later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_enable   <= 1'b0;
      infrared_select <= 1'b0;
      full_scale_span <= 2'b00;
    end else begin
      analog_enable   <= (eng_ff != LSC_ENG_OFF);
      infrared_select <= cmd_ff[CMD_LIGHT_BIT];
      full_scale_span <= cmd_ff[SPAN_SELECT_HIGH:SPAN_SELECT_LOW];
    end
  end
endmodule

/* File: src/lsc_pkg.sv */
/*
  Shared constants of the light sensor command and data block: register
  offsets, command field positions, integration cycle counts, serial address,
  oscillator rate and reset values.
  Assumes a single system clock of 125 MHz; all other rates derive from it.
*/
package lsc_pkg;
  // register offsets
  localparam logic [6:0] REG_COMMAND_CONTROL  = 7'h00;
  localparam logic [6:0] REG_RESULT_LOW_BYTE  = 7'h01;
  localparam logic [6:0] REG_RESULT_HIGH_BYTE = 7'h02;
  localparam int         SYNC_ADDR_BIT        = 7;

  // command field positions
  localparam int CMD_ENABLE_BIT    = 7;
  localparam int CMD_MODE_BIT      = 6;
  localparam int CMD_LIGHT_BIT     = 5;
  localparam int TIMING_SOURCE_BIT = 4;
  localparam int CYCLE_COUNT_HIGH  = 3;
  localparam int CYCLE_COUNT_LOW   = 2;
  localparam int SPAN_SELECT_HIGH  = 1;
  localparam int SPAN_SELECT_LOW   = 0;

  // values after reset
  localparam logic [7:0]  COMMAND_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;

  // serial slave address, low bit taken from the address select pin
  localparam logic [5:0] SLAVE_ADDR_HIGH = 6'h22;

  // integration cycle counts for the four internal resolutions
  localparam logic [16:0] CYCLES_RES16 = 17'h10000;
  localparam logic [16:0] CYCLES_RES12 = 17'h01000;
  localparam logic [16:0] CYCLES_RES8  = 17'h00100;
  localparam logic [16:0] CYCLES_RES4  = 17'h00010;
  localparam logic [16:0] COUNT_MAX    = 17'h0ffff;

  // internal oscillator tick derived from the system clock
  localparam int SYS_CLK_HZ               = 125_000_000;
  localparam int INTERNAL_OSCILLATOR_RATE = 725_000;
  localparam int OSC_DIV_CYCLES           = SYS_CLK_HZ / INTERNAL_OSCILLATOR_RATE;

  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_POST = 4'h9;

  typedef enum logic [2:0] {
    LSC_BUS_IDLE, LSC_BUS_ADDR, LSC_BUS_REG, LSC_BUS_WR, LSC_BUS_RD
  } lsc_bus_t;

  typedef enum logic [1:0] {LSC_ENG_OFF, LSC_ENG_WAIT, LSC_ENG_RUN} lsc_eng_t;
endpackage

/* File: verification/lsc_bus_master.sv */
/*
  two-wire bus master model for the sensor's serial pins.
  assumes a pull-up on sda: a released line reads high; scl rests high.
*/
module lsc_bus_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25;
  logic [6:0] dev = 7'h44;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // drive b (1 releases) and sample the wire at the end of scl high
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #Q sda_drv = b;
    #Q scl = 1'b1;
    #(2*Q) s = sda_wire;
  endtask
  // a=1 start, a=0 stop
  task automatic cond(input logic a);
    scl = 1'b0;
    #Q sda_drv = a;
    #Q scl = 1'b1;
    #Q sda_drv = !a;
    #Q;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, a);
  endtask
  // register byte with bit 7 set restarts external integration
  task automatic wr(input logic [7:0] r, d, input logic dat, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    cond(1'b1);
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(r, 1'b1, q, a1);
    a2 = 1'b0;
    if (dat) byte_io(d, 1'b1, q, a2);
    cond(1'b0);
    ok = !(a0 | a1 | a2);
  endtask
  task automatic rd(input logic [7:0] r, output logic [15:0] v, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    cond(1'b1);
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(r, 1'b1, q, a1);
    cond(1'b1);
    byte_io({dev, 1'b1}, 1'b1, q, a2);
    byte_io(8'hff, 1'b0, v[7:0], a3);
    byte_io(8'hff, 1'b1, v[15:8], a3);
    cond(1'b0);
    ok = !(a0 | a1 | a2);
  endtask
endmodule

/* File: verification/lsc_monitor.sv */
/*
  port checker of the light sensor block.
  assumes it is bound to the sensor; only the sensor's ports are seen.
*/
module lsc_monitor (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       address_select_pin,
  input wire logic       ambient_pulse,
  input wire logic       infrared_pulse,
  input wire logic       analog_enable,
  input wire logic       infrared_select,
  input wire logic [1:0] full_scale_span,
  input wire logic       conversion_done
);
  timeunit 1ns;
  timeprecision 10ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_done_single: assert property (
    conversion_done |=> !conversion_done) else $error("done held too long");
  a_done_powered: assert property (
    conversion_done |-> $past(analog_enable, 2)) else $error("done while unpowered");
  a_off_no_done: assert property (
    !analog_enable [*3] |=> !conversion_done) else $error("done after power down");
  a_wake_no_done: assert property (
    $rose(analog_enable) |-> !conversion_done [*3]) else $error("conversion too short");
  a_oe_moves_low: assert property (
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2)) else $error("sda moved with scl high");
  a_span_after_ack: assert property (
    $changed(full_scale_span) |-> !$past(scl_in, 4)) else $error("span moved off ack");
  a_light_after_ack: assert property (
    $changed(infrared_select) |-> !$past(scl_in, 4)) else $error("light moved off ack");
  a_open_drain: assert property (
    sda_out == 1'b0) else $error("sda driven high");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !sda_oe && !analog_enable) else $error("active in reset");
  cover property (conversion_done);
  cover property ($rose(sda_oe));
  cover property ($fell(analog_enable));
endmodule

bind lsc_light_sensor lsc_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .address_select_pin(address_select_pin), .ambient_pulse(ambient_pulse),
  .infrared_pulse(infrared_pulse), .analog_enable(analog_enable),
  .infrared_select(infrared_select), .full_scale_span(full_scale_span),
  .conversion_done(conversion_done));

/* File: verification/test_light_sensor_command_and_data.sv */
/*
  self-checking bench of the light sensor block.
  assumes the bus master model and the bound checker are compiled first.
*/
module test_light_sensor_command_and_data;
  timeunit 1ns;
  timeprecision 10ps;
  localparam int DIV = 2;
  // cycles from the data ack fall to the end of the stop, less the sync delay
  localparam int WR_TAIL = 28;
  logic sys_clk = 1'b0, rst_n = 1'b0, pin = 1'b0, amb_on = 1'b0, ir_on = 1'b0;
  logic amb = 1'b0, ir = 1'b0, scl, sda_drv, sda_oe, sda_out, ana, irs, done, ok;
  logic [1:0] span;
  logic [15:0] v, r0;
  wire logic sda_w = sda_drv & ~sda_oe;
  int err_count = 0, samples_checked = 0, ph = 0, n;
  time t0, t1;
  initial forever #4 sys_clk = ~sys_clk;
  // photodiode pulses: period 6 cycles, 3 high
  always @(posedge sys_clk) begin
    ph <= (ph == 5) ? 0 : ph + 1;
    amb <= #1 amb_on && ph < 3;
    ir <= #1 ir_on && ph < 3;
  end
  lsc_light_sensor #(.OSC_DIV(DIV)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(pin), .ambient_pulse(amb), .infrared_pulse(ir),
    .analog_enable(ana), .infrared_select(irs), .full_scale_span(span),
    .conversion_done(done));
  lsc_bus_master i_m (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_w));
  task automatic check(input logic [16:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic logic near(input logic [16:0] s, e, t);
    return s + t >= e && s <= e + t;
  endfunction
  task automatic clk(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_done(output int c);
    c = 0;
    while (done !== 1'b1 && c < 20000) begin
      @(posedge sys_clk);
      #2 c++;
    end
    check(c < 20000, 1);
  endtask
  task automatic w(input logic [7:0] r, d);
    i_m.wr(r, d, 1'b1, ok);
    check(ok, 1);
  endtask
  task automatic rd(input logic [7:0] r);
    i_m.rd(r, v, ok);
    check(ok, 1);
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #600000;
    err_count++;
    stop_test();
  end
  initial begin
    clk(3);
    rst_n = 1'b1;
    clk(3);
    rd(8'h00);
    check(v[7:0], 8'h00);
    rd(8'h01);
    check(v, 16'h0000);
    pin = 1'b1;
    clk(4);
    i_m.wr(8'h00, 8'had, 1'b1, ok);
    check(ok, 0);
    i_m.dev = 7'h45;
    ir_on = 1'b1;
    w(8'h00, 8'had);
    check(irs, 1);
    check(span, 2'b01);
    wait_done(n);
    clk(4);
    check(ana, 0);
    rd(8'h01);
    r0 = v;
    check(near(v, 17'(16 * DIV / 6), 2), 1);
    rd(8'h00);
    check(v[7:0], 8'had);
    w(8'h01, 8'hff);
    clk(200);
    rd(8'h01);
    check(v, r0);
    rd(8'h02);
    check(v, {8'h00, r0[15:8]});
    ir_on = 1'b0;
    amb_on = 1'b1;
    // timing codes 001..011: the 12, 8 and 4 bit internal integrations
    for (int k = 1; k < 4; k++) begin
      w(8'h00, 8'h80 | 8'(k << 2));
      wait_done(n);
      check(near(17'(n), 17'((65536 >> 4 * k) * DIV - WR_TAIL), 24), 1);
      clk(2);
      rd(8'h01);
      check(near(v, 17'((65536 >> 4 * k) * DIV / 6), 3), 1);
    end
    w(8'h00, 8'hcc);
    wait_done(n);
    n = 0;
    repeat (256) begin
      clk(1);
      n += done;
    end
    check(near(17'(n), 8, 1), 1);
    check(ana, 1);
    rd(8'h01);
    check(near(v, 5, 2), 1);
    w(8'h00, 8'h00);
    clk(4);
    check(ana, 0);
    w(8'h00, 8'hd4);
    i_m.wr(8'h80, 8'h00, 1'b0, ok);
    t0 = $time;
    clk(400);
    i_m.wr(8'h80, 8'h00, 1'b0, ok);
    t1 = $time;
    rd(8'h01);
    check(near(v, 17'((t1 - t0) / (8 * DIV)), 2), 1);
    w(8'h00, 8'hd0);
    rd(8'h01);
    check(near(v, 17'((t1 - t0) / 48), 2), 1);
    w(8'h00, 8'h00);
    stop_test();
  end
endmodule
